// file: bao_alu.sv
`timescale 1ns/1ps
module bao_alu (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pin direction outputs.
  output logic [7:0] dir6_o,
  output logic [7:0] dir7_o
);

  // ==========================================================================
  // State.
  logic [7:0] acc;
  logic [7:0] operand;
  logic carry_flag;
  logic digit_carry_flag;
  logic zero_flag;
  logic [7:0] file_mem [bao_pkg::FILE_DEPTH];
  logic [31:0] rdata;

  // ==========================================================================
  // Bus decode.
  // Every access is acknowledged in the cycle after the strobe; masking the
  // request with ack keeps a held strobe from being taken twice.
  wire req = cyc_i & stb_i & ~ack_o;
  wire wr = req & we_i & sel_i[0];
  wire wr_cmd = wr & (adr_i == bao_pkg::ADDR_CMD);
  wire wr_opnd = wr & (adr_i == bao_pkg::ADDR_OPND);
  wire wr_acc = wr & (adr_i == bao_pkg::ADDR_ACC);
  wire wr_stat = wr & (adr_i == bao_pkg::ADDR_STATUS);
  wire in_file = adr_i[7] == 1'b1;
  wire [4:0] widx = adr_i[6:2];
  wire wr_file = wr & in_file;

  // ==========================================================================
  // Command fields: op, destination bit, file address.
  wire [2:0] op = dat_i[bao_pkg::CMD_OP_LSB +: 3];
  wire dest = dat_i[bao_pkg::CMD_DEST_BIT];
  wire [4:0] faddr = dat_i[bao_pkg::CMD_ADDR_LSB +: 5];
  wire [7:0] fval = file_mem[faddr];

  // Direction select compares the whole file address, so addresses that
  // only alias 6 or 7 in their low bits load nothing.
  function automatic logic dir_hit(input logic [4:0] a,
    input logic [2:0] sel);
    return a == {2'b00, sel};
  endfunction

  // ==========================================================================
  // Arithmetic and logic results.
  // Subtract as file plus inverted accumulator plus one, so carry out is
  // the inverse of borrow without a separate compare.
  wire [8:0] diff = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
  wire [4:0] ldiff = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire [7:0] rot = {carry_flag, fval[7:1]};
  wire [7:0] swp = {fval[3:0], fval[7:4]};
  wire [7:0] xf = acc ^ fval;
  wire [7:0] xl = acc ^ operand;

  // ==========================================================================
  // Result selection and flag update enables.
  logic [7:0] res;
  logic is_file_op;
  logic op_known;
  logic upd_c;
  logic upd_dcz;
  logic upd_z;
  logic next_c;
  always_comb
  begin
    res = 8'h00;
    is_file_op = 1'b1;
    op_known = 1'b1;
    upd_c = 1'b0;
    upd_dcz = 1'b0;
    upd_z = 1'b0;
    next_c = carry_flag;
    case (bao_pkg::bao_op_e'(op))
      bao_pkg::OP_SUBTRACT_ACC_FROM_FILE:
      begin
        res = diff[7:0];
        upd_c = 1'b1;
        upd_dcz = 1'b1;
        next_c = diff[8];
      end
      bao_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY:
      begin
        res = rot;
        upd_c = 1'b1;
        next_c = fval[0];
      end
      bao_pkg::OP_NIBBLE_EXCHANGE: res = swp;
      bao_pkg::OP_XOR_ACC_WITH_FILE:
      begin
        res = xf;
        upd_z = 1'b1;
      end
      bao_pkg::OP_XOR_ACC_WITH_LITERAL:
      begin
        res = xl;
        upd_z = 1'b1;
        is_file_op = 1'b0;
      end
      default:
      begin
        is_file_op = 1'b0;
        op_known = 1'b0;
      end
    endcase
  end

  // Only the five result-producing codes touch the accumulator, files or
  // flags; codes 0 and 7 and the direction load fall through untouched.
  wire load_dir = wr_cmd && (op == bao_pkg::OP_LOAD_PIN_DIRECTION);
  wire alu_op = wr_cmd && op_known;
  wire hit6 = load_dir && dir_hit(faddr, bao_pkg::DIR_SEL_LO);
  wire hit7 = load_dir && dir_hit(faddr, bao_pkg::DIR_SEL_HI);
  wire to_file = alu_op && is_file_op && dest;
  wire to_acc = alu_op && !(is_file_op && dest);

  // ==========================================================================
  // Accumulator, operand and flags.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc <= bao_pkg::RESET_BYTE;
      operand <= bao_pkg::RESET_BYTE;
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag <= 1'b0;
    end
    else
    begin
      if (to_acc)
        acc <= res;
      else if (wr_acc)
        acc <= dat_i[7:0];
      if (wr_opnd)
        operand <= dat_i[7:0];
      if (alu_op && upd_c)
        carry_flag <= next_c;
      else if (wr_stat)
        carry_flag <= dat_i[bao_pkg::STAT_C];
      if (alu_op && upd_dcz)
        digit_carry_flag <= ldiff[4];
      else if (wr_stat)
        digit_carry_flag <= dat_i[bao_pkg::STAT_DIGIT];
      if (alu_op && (upd_dcz || upd_z))
        zero_flag <= (res == 8'h00);
      else if (wr_stat)
        zero_flag <= dat_i[bao_pkg::STAT_Z];
    end
  end

  // ==========================================================================
  // File register array; results land here only when the destination is set.
  // The array has no reset, so software must load a register before use.
  always_ff @(posedge clk_i)
  begin
    if (to_file)
      file_mem[faddr] <= res;
    else if (wr_file)
      file_mem[widx] <= dat_i[7:0];
  end

  // ==========================================================================
  // Pin direction registers, all inputs after reset; flags untouched.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dir6_o <= bao_pkg::DIR_RESET;
      dir7_o <= bao_pkg::DIR_RESET;
    end
    else if (hit6)
      dir6_o <= acc;
    else if (hit7)
      dir7_o <= acc;
  end

  // ==========================================================================
  // Read mux; unmapped addresses read zero.
  always_comb
  begin
    rdata = 32'h00000000;
    if (in_file)
      rdata = {24'h000000, file_mem[widx]};
    else
      case (adr_i)
        bao_pkg::ADDR_OPND: rdata = {24'h000000, operand};
        bao_pkg::ADDR_ACC: rdata = {24'h000000, acc};
        bao_pkg::ADDR_STATUS:
          rdata = {29'h00000000, zero_flag, digit_carry_flag, carry_flag};
        bao_pkg::ADDR_DIR6: rdata = {24'h000000, dir6_o};
        bao_pkg::ADDR_DIR7: rdata = {24'h000000, dir7_o};
        default: rdata = 32'h00000000;
      endcase
  end

  // ==========================================================================
  // Acknowledge and registered read data.
  // Read data is registered beside ack, so it stands in the ack cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= rdata;
    end
  end

endmodule

// file: bao_pkg.sv
package bao_pkg;

  // ==========================================================================
  // Register bus map (byte addresses, one word per register).
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_OPND = 8'h04;
  localparam logic [7:0] ADDR_ACC = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_DIR6 = 8'h10;
  localparam logic [7:0] ADDR_DIR7 = 8'h14;
  localparam logic [7:0] ADDR_FILE = 8'h80;

  // ==========================================================================
  // Command register fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 4;
  localparam int CMD_ADDR_LSB = 8;

  // ==========================================================================
  // Status register bit positions and reset values.
  localparam int STAT_C = 0;
  localparam int STAT_DIGIT = 1;
  localparam int STAT_Z = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [2:0] DIR_SEL_LO = 3'h6;
  localparam logic [2:0] DIR_SEL_HI = 3'h7;
  localparam int FILE_DEPTH = 32;

  // ==========================================================================
  // Operation codes.
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SUBTRACT_ACC_FROM_FILE = 3'b001,
    OP_ROTATE_RIGHT_THROUGH_CARRY = 3'b010,
    OP_NIBBLE_EXCHANGE = 3'b011,
    OP_LOAD_PIN_DIRECTION = 3'b100,
    OP_XOR_ACC_WITH_FILE = 3'b101,
    OP_XOR_ACC_WITH_LITERAL = 3'b110
  } bao_op_e;

endpackage

// file: bao_alu_asserts.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the bus handshake and the direction outputs.
module bao_alu_asserts (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus side.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Direction outputs.
  input wire logic [7:0] dir6_o,
  input wire logic [7:0] dir7_o
);
  // A request is taken only while no answer is pending.
  wire req = cyc_i && stb_i && !ack_o;
  wire rd_req = req && !we_i;
  wire ld = req && we_i && sel_i[0] && adr_i == bao_pkg::ADDR_CMD &&
    dat_i[2:0] == bao_pkg::OP_LOAD_PIN_DIRECTION;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack held");
  AST_ACK_NEXT: assert property (req |=> ack_o) else $error("no ack");
  AST_ACK_CAUSE: assert property (!req |=> !ack_o) else $error("stray ack");
  AST_DIR6: assert property (
    $changed(dir6_o) |-> $past(ld && dat_i[12:8] == 5'h06))
    else $error("dir6 moved");
  AST_DIR7: assert property (
    $changed(dir7_o) |-> $past(ld && dat_i[12:8] == 5'h07))
    else $error("dir7 moved");
  AST_CMD_READ: assert property (
    rd_req && adr_i == bao_pkg::ADDR_CMD |=> dat_o == 32'h0)
    else $error("cmd read not zero");
  AST_HIGH_ZERO: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper data set");
  AST_STAT_BITS: assert property (
    rd_req && adr_i == bao_pkg::ADDR_STATUS |=> dat_o[7:3] == 5'h00)
    else $error("status spare bits");
  // Main traffic kinds worth seeing at least once.
  cover property (ld);
  cover property (rd_req && adr_i == bao_pkg::ADDR_STATUS);
  cover property (req && we_i && !sel_i[0]);
endmodule
bind bao_alu bao_alu_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dir6_o(dir6_o),
  .dir7_o(dir7_o));

// file: bao_alu_bench.sv
`timescale 1ns/1ps
// ==========================================================================
// Random bench with a reference model of the operations.
module bao_alu_bench;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [7:0] adr_i = 0, acc = 0, lit, rd, d6 = 8'hFF, d7 = 8'hFF, dir6_o;
  logic [7:0] dir7_o, fr[8];
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o;
  logic [2:0] st = 0;
  int error_cnt = 0, check_count = 0, seed = 31, i;
  bao_alu uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .dir6_o(dir6_o), .dir7_o(dir7_o));
  // The clock runs free at 100 ns.
  initial forever #50 clk_i = ~clk_i;
  // Expected flags, zero over digit carry over carry, and the result.
  // Carry set means no borrow.
  function automatic logic [10:0] model(input logic [2:0] op,
    input logic [7:0] v, w, k, input logic [2:0] s);
    logic [8:0] d;
    d = {1'b0, v} - {1'b0, w};
    case (op)
      1: return {d[7:0] == 0, v[3:0] >= w[3:0], !d[8], d[7:0]};
      2: return {s[2:1], v[0], s[0], v[7:1]};
      3: return {s, v[3:0], v[7:4]};
      5: return {(v ^ w) == 0, s[1:0], v ^ w};
      6: return {(k ^ w) == 0, s[1:0], k ^ w};
      default: return {s, w};
    endcase
  endfunction
  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the wait is bounded so a dead slave ends the run.
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [15:0] d, input logic s0);
    int n;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= {3'h7, s0};
    dat_i <= {16'h0, d};
    for (n = 0; n < 20 && ack_o !== 1'b1; n++)
      @(posedge clk_i);
    if (ack_o !== 1'b1)
    begin
      error_cnt++;
      stop_test();
    end
    rd = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 16'h0, 1'b1);
    chk(rd, e);
  endtask
  // Issues a command and moves the reference state the same way.
  task automatic cmd(input logic [2:0] op, input logic d, input logic [2:0] f);
    logic [10:0] m;
    logic fop;
    m = model(op, fr[f], acc, lit, st);
    fop = op != 3'h0 && op != 3'h4 && op != 3'h6 && op != 3'h7;
    wb(1'b1, bao_pkg::ADDR_CMD, {5'h0, f, 3'h0, d, 1'b0, op}, 1'b1);
    st = m[10:8];
    if (op == 4 && f == 6) d6 = acc;
    if (op == 4 && f == 7) d7 = acc;
    if (op == 3'h6 || (fop && !d)) acc = m[7:0];
    else if (fop) fr[f] = m[7:0];
    rc(bao_pkg::ADDR_ACC, acc);
    rc(bao_pkg::ADDR_STATUS, {5'h0, st});
    rc(bao_pkg::ADDR_FILE + {3'h0, f, 2'h0}, fr[f]);
    chk(dir6_o, d6);
    chk(dir7_o, d7);
  endtask
  // Reset, corner cases, then every operation in random mixes.
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    for (i = 0; i < 8; i++)
    begin
      fr[i] = 8'($random(seed));
      wb(1'b1, bao_pkg::ADDR_FILE + 8'(4 * i), {8'h0, fr[i]}, 1'b1);
    end
    wb(1'b1, bao_pkg::ADDR_ACC, 16'h5A, 1'b0);
    rc(bao_pkg::ADDR_ACC, 8'h00);
    rc(8'h40, 8'h00);
    acc = fr[2];
    wb(1'b1, bao_pkg::ADDR_ACC, {8'h0, acc}, 1'b1);
    cmd(3'h1, 1'b0, 3'h2);
    // Flags written by software, then a rotate that consumes the carry.
    st = 3'h5;
    wb(1'b1, bao_pkg::ADDR_STATUS, {13'h0, st}, 1'b1);
    cmd(3'h2, 1'b1, 3'h3);
    // Codes 0 and 7 must leave every register and flag alone.
    cmd(3'h0, 1'b1, 3'h4);
    cmd(3'h7, 1'b0, 3'h5);
    // A direction load whose address only aliases 6 is ignored.
    wb(1'b1, bao_pkg::ADDR_CMD, 16'h0E04, 1'b1);
    chk(dir6_o, d6);
    cmd(3'h4, 1'b0, 3'h6);
    rc(bao_pkg::ADDR_DIR6, d6);
    rc(bao_pkg::ADDR_DIR7, d7);
    lit = 8'h3C;
    wb(1'b1, bao_pkg::ADDR_OPND, {8'h0, lit}, 1'b1);
    rc(bao_pkg::ADDR_OPND, lit);
    for (i = 0; i < 240; i++)
    begin
      lit = 8'($random(seed));
      wb(1'b1, bao_pkg::ADDR_OPND, {8'h0, lit}, 1'b1);
      if (i % 3 == 0) acc = 8'($random(seed));
      wb(1'b1, bao_pkg::ADDR_ACC, {8'h0, acc}, 1'b1);
      cmd(3'(i % 6 + 1), 1'($random(seed)), 3'($random(seed)));
    end
    stop_test();
  end
endmodule
